// File: hw/asbw_pkg.sv
/*
  Constants shared by the byte-wide static memory host controller:
  pin widths, timing figures in ns, cycle counts and the sequencer states.
  Assumes a single 40 MHz system clock.
*/
`default_nettype none

package asbw_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;

  // ==========================================================
  // clock and timing figures (slower grade where two are given)
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_AA_NS = 12;
  localparam int T_RC_NS = 12;
  localparam int T_HZCS_NS = 7;
  localparam int T_AW_NS = 10;
  localparam int T_PWE1_NS = 9;
  localparam int T_SD_NS = 7;

  // least times round up to whole cycles
  localparam int T_AA_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HZ_CYC = (T_HZCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_AW_CYC = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_PWE_CYC = (T_PWE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_SD_CYC = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // three flops plus the settled register
  localparam int SYNC_LAT_CYC = 4;

  localparam int WR_PULSE_CYC =
    (T_AW_CYC > T_PWE_CYC) ? ((T_AW_CYC > T_SD_CYC) ? T_AW_CYC : T_SD_CYC)
                           : ((T_PWE_CYC > T_SD_CYC) ? T_PWE_CYC : T_SD_CYC);

  // counter load values (state lasts load + 1 cycles)
  localparam logic [CNT_W-1:0] RD_WAIT_LOAD =
    CNT_W'(T_AA_CYC + SYNC_LAT_CYC);
  localparam logic [CNT_W-1:0] RD_END_LOAD = CNT_W'(T_HZ_CYC - 1);
  localparam logic [CNT_W-1:0] WR_PULSE_LOAD = CNT_W'(WR_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOV_LOAD = CNT_W'(T_RC_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_RD_END,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_STBY,
    ST_RECOV
  } asbw_state_t;

endpackage : asbw_pkg

`default_nettype wire

// File: hw/asbw_sync_if.sv
/*
  Carrier between the controller and its data-line input synchroniser.
  Assumes both ends run on the same system clock.
*/
`default_nettype none

interface asbw_sync_if;
  logic [asbw_pkg::DATA_W-1:0] raw;
  logic [asbw_pkg::DATA_W-1:0] settled;

  modport ctrl (output raw, input settled);
  modport sync (input raw, output settled);
endinterface : asbw_sync_if

`default_nettype wire

// File: hw/asbw_in_sync.sv
/*
  Three-flop synchroniser for the memory's data lines; the settled value
  follows once the second and third stages agree.
  Assumes raw comes straight from the pins, outside the clock domain.
*/
`default_nettype none

module asbw_in_sync (
  input wire logic clk_sys,
  input wire logic reset,
  asbw_sync_if.sync link
);

  logic [asbw_pkg::DATA_W-1:0] stage1_reg;
  logic [asbw_pkg::DATA_W-1:0] stage2_reg;
  logic [asbw_pkg::DATA_W-1:0] stage3_reg;
  logic [asbw_pkg::DATA_W-1:0] settled_reg;
  wire agree = (stage2_reg == stage3_reg);

  // ==========================================================
  // stages
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1_reg <= asbw_pkg::DATA_RST;
      stage2_reg <= asbw_pkg::DATA_RST;
      stage3_reg <= asbw_pkg::DATA_RST;
      settled_reg <= asbw_pkg::DATA_RST;
    end else begin
      stage1_reg <= link.raw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (agree) begin
        settled_reg <= stage3_reg;
      end
    end
  end

  assign link.settled = settled_reg;

endmodule : asbw_in_sync

`default_nettype wire

// File: hw/asbw_host_ctrl.sv
/*
  Host controller for an asynchronous byte-wide static memory: takes read
  and write requests and standby requests from user logic and sequences
  the select, output-drive and write strobes, address and data lines.
  Assumes user logic is on clk_sys and the memory is the only other
  driver of the data lines.
*/
`default_nettype none

module asbw_host_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asbw_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asbw_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asbw_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic standby_req,
  output logic standby_ack,
  output logic [asbw_pkg::ADDR_W-1:0] word_select_lines,
  output logic chip_sel_n,
  output logic out_drive_n,
  output logic write_strobe_n,
  input wire logic [asbw_pkg::DATA_W-1:0] byte_data_in,
  output logic [asbw_pkg::DATA_W-1:0] byte_data_out,
  output logic byte_data_oe
);

  asbw_pkg::asbw_state_t state_reg;
  asbw_pkg::asbw_state_t state_next;
  logic [asbw_pkg::CNT_W-1:0] cnt_reg;
  logic [asbw_pkg::CNT_W-1:0] cnt_next;
  logic [asbw_pkg::ADDR_W-1:0] addr_reg;
  logic [asbw_pkg::DATA_W-1:0] wdata_reg;
  logic [asbw_pkg::DATA_W-1:0] rdata_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  logic stby_ack_reg;
  logic cs_n_reg;
  logic oe_n_reg;
  logic we_n_reg;
  logic data_oe_reg;

  asbw_sync_if data_sync ();

  asbw_in_sync u_in_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .link(data_sync)
  );

  assign data_sync.raw = byte_data_in;

  // ==========================================================
  // decode
  wire accept = req_valid && ready_reg && (state_reg == asbw_pkg::ST_IDLE);
  wire cnt_done = (cnt_reg == asbw_pkg::CNT_ZERO);
  wire state_moves = (state_next != state_reg);
  wire rd_capture = (state_reg == asbw_pkg::ST_RD_WAIT) && cnt_done;

  // select low only in the access phases; otherwise
  wire cs_n_next = !((state_next == asbw_pkg::ST_RD_WAIT) ||
                     (state_next == asbw_pkg::ST_WR_PULSE));
  // output drive only during the read access
  wire oe_n_next = (state_next != asbw_pkg::ST_RD_WAIT);
  // write strobe low only together with select; high on every read
  wire we_n_next = (state_next != asbw_pkg::ST_WR_PULSE);
  // drive data from setup to one cycle past the write end
  wire data_oe_next = (state_next == asbw_pkg::ST_WR_SETUP) ||
                      (state_next == asbw_pkg::ST_WR_PULSE) ||
                      (state_next == asbw_pkg::ST_WR_END);
  wire ready_next = (state_next == asbw_pkg::ST_IDLE) && !standby_req;

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      asbw_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = req_write ? asbw_pkg::ST_WR_SETUP
                                 : asbw_pkg::ST_RD_SETUP;
        end else if (standby_req) begin
          state_next = asbw_pkg::ST_STBY;
        end
      end
      asbw_pkg::ST_RD_SETUP: state_next = asbw_pkg::ST_RD_WAIT;
      asbw_pkg::ST_RD_WAIT: begin
        if (cnt_done) begin
          state_next = asbw_pkg::ST_RD_END;
        end
      end
      asbw_pkg::ST_RD_END: begin
        if (cnt_done) begin
          state_next = asbw_pkg::ST_IDLE;
        end
      end
      asbw_pkg::ST_WR_SETUP: state_next = asbw_pkg::ST_WR_PULSE;
      asbw_pkg::ST_WR_PULSE: begin
        if (cnt_done) begin
          state_next = asbw_pkg::ST_WR_END;
        end
      end
      asbw_pkg::ST_WR_END: state_next = asbw_pkg::ST_IDLE;
      asbw_pkg::ST_STBY: begin
        if (!standby_req) begin
          state_next = asbw_pkg::ST_RECOV;
        end
      end
      asbw_pkg::ST_RECOV: begin
        if (cnt_done) begin
          state_next = asbw_pkg::ST_IDLE;
        end
      end
      default: state_next = asbw_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // phase counter, loaded on entry to each timed state
  always_comb begin
    cnt_next = cnt_done ? asbw_pkg::CNT_ZERO : cnt_reg - 4'h1;
    if (state_moves) begin
      unique case (state_next)
        asbw_pkg::ST_RD_WAIT: cnt_next = asbw_pkg::RD_WAIT_LOAD;
        asbw_pkg::ST_RD_END: cnt_next = asbw_pkg::RD_END_LOAD;
        asbw_pkg::ST_WR_PULSE: cnt_next = asbw_pkg::WR_PULSE_LOAD;
        asbw_pkg::ST_RECOV: cnt_next = asbw_pkg::RECOV_LOAD;
        default: cnt_next = asbw_pkg::CNT_ZERO;
      endcase
    end
  end

  // ==========================================================
  // state and pin registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= asbw_pkg::ST_IDLE;
      cnt_reg <= asbw_pkg::CNT_ZERO;
      ready_reg <= 1'b0;
      stby_ack_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      data_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      stby_ack_reg <= (state_next == asbw_pkg::ST_STBY);
      cs_n_reg <= cs_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      data_oe_reg <= data_oe_next;
    end
  end

  // address and data change only on acceptance; held past the write end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_reg <= asbw_pkg::ADDR_RST;
      wdata_reg <= asbw_pkg::DATA_RST;
    end else if (accept) begin
      addr_reg <= req_addr;
      wdata_reg <= req_wdata;
    end
  end

  // read answer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rsp_valid_reg <= 1'b0;
      rdata_reg <= asbw_pkg::DATA_RST;
    end else begin
      rsp_valid_reg <= rd_capture;
      if (rd_capture) begin
        rdata_reg <= data_sync.settled;
      end
    end
  end

  assign req_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rdata_reg;
  assign standby_ack = stby_ack_reg;
  assign word_select_lines = addr_reg;
  assign chip_sel_n = cs_n_reg;
  assign out_drive_n = oe_n_reg;
  assign write_strobe_n = we_n_reg;
  assign byte_data_out = wdata_reg;
  assign byte_data_oe = data_oe_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  rd_strobe_high_a: assert property (
    !out_drive_n |-> write_strobe_n && !chip_sel_n
  ) else $error("write strobe low while output drive is low");

  rd_addr_setup_a: assert property (
    $fell(chip_sel_n) |-> $stable(word_select_lines)
  ) else $error("address changed at the select falling edge");

  wr_overlap_a: assert property (
    $rose(write_strobe_n) |-> $rose(chip_sel_n) && byte_data_oe
  ) else $error("write did not end on both strobes together");

  wr_strobe_sel_a: assert property (
    !write_strobe_n |-> !chip_sel_n && out_drive_n
  ) else $error("write strobe low without select or with output drive");

  wr_addr_setup_a: assert property (
    $rose(write_strobe_n) |->
      $stable(word_select_lines) && $past(word_select_lines, 2) ==
      word_select_lines
  ) else $error("address not stable before the write end");

  wr_data_setup_a: assert property (
    $rose(write_strobe_n) |->
      $past(byte_data_oe, 2) && $stable(byte_data_out)
  ) else $error("write data not set up before the write end");

  wr_pulse_width_a: assert property (
    $fell(write_strobe_n) |-> out_drive_n ##1 write_strobe_n
  ) else $error("write strobe pulse not one cycle with drive high");

  wr_data_hold_a: assert property (
    $rose(write_strobe_n) |=> !byte_data_oe && $stable(word_select_lines)
  ) else $error("write data not released one cycle after the end");

  bus_turn_a: assert property (
    byte_data_oe |-> out_drive_n
  ) else $error("data lines driven while the memory may drive");

  stby_recover_a: assert property (
    $fell(standby_ack) |-> chip_sel_n && !req_ready ##1 chip_sel_n
  ) else $error("access started without a recovery cycle");

  rd_answer_a: assert property (
    (req_valid && req_ready && !req_write) |-> ##8 rsp_valid
  ) else $error("read answer not given eight cycles after acceptance");

  desel_quiet_a: assert property (
    chip_sel_n |-> out_drive_n && write_strobe_n
  ) else $error("strobe active while the memory is deselected");

  wr_pulse_state_a: assert property (
    (state_reg == asbw_pkg::ST_WR_PULSE) |-> !write_strobe_n && !chip_sel_n
  ) else $error("write strobe not low through the write pulse");

  rd_drive_len_a: assert property (
    $fell(out_drive_n) |-> !out_drive_n [*6] ##1 out_drive_n
  ) else $error("output drive not held for the read access time");

  ready_quiet_a: assert property (
    req_ready |-> chip_sel_n && !byte_data_oe
  ) else $error("ready raised while the data lines are still driven");

  stby_desel_a: assert property (
    standby_ack |-> chip_sel_n && !req_ready
  ) else $error("select or ready active during standby");

  rsp_pulse_a: assert property (
    rsp_valid |=> !rsp_valid
  ) else $error("read answer held longer than one cycle");

  wr_data_early_a: assert property (
    !write_strobe_n |-> byte_data_oe && $past(byte_data_oe)
  ) else $error("write data not driven a cycle before the strobe");

  wr_addr_hold_a: assert property (
    (state_reg == asbw_pkg::ST_WR_END) |-> $stable(word_select_lines)
  ) else $error("address moved before the write had ended");

  sel_addr_stable_a: assert property (
    !chip_sel_n |-> $stable(word_select_lines)
  ) else $error("address changed while the memory is selected");

endmodule : asbw_host_ctrl

`default_nettype wire

// File: test/asbw_mem_model.sv
/*
  Behavioural model of the byte-wide static memory on the far side.
  Assumes the bench resolves the shared data wire and feeds it back as dq.
*/
`default_nettype none

module asbw_mem_model (
  input wire logic [asbw_pkg::ADDR_W-1:0] addr,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [asbw_pkg::DATA_W-1:0] dq,
  output logic [asbw_pkg::DATA_W-1:0] q,
  output logic drive,
  output logic [7:0] viol
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:32767];
  logic [7:0] rd_now;
  logic [7:0] rd_del;
  logic [7:0] last;
  logic wr_act;
  logic in_wr;
  event mem_wr_ev;
  realtime t_addr, t_dq, t_wr;

  // ==========================================================
  // select truth table and read path
  assign drive = !cs_n && we_n && !oe_n;
  assign wr_act = !cs_n && !we_n;
  always @(addr or mem_wr_ev) rd_now = mem[addr];
  assign #10 rd_del = rd_now;

  initial begin
    last = 8'h00;
    q = 8'hFF;
    viol = 8'h00;
    in_wr = 1'b0;
  end

  // released lines show the inverse of the last value
  always @(drive or rd_del) begin
    if (drive) last = rd_del;
    q = drive ? rd_del : ~last;
  end

  // ==========================================================
  // write capture and setup checks at the ending edge
  always @(addr) t_addr = $realtime;
  always @(dq) t_dq = $realtime;
  always @(posedge wr_act) begin
    t_wr = $realtime;
    in_wr = 1'b1;
  end
  always @(negedge wr_act) begin
    if (in_wr) begin
      mem[addr] = dq;
      -> mem_wr_ev;
      if ($realtime - t_addr < 10.0) viol = viol + 8'h01;
      if ($realtime - t_dq < 7.0) viol = viol + 8'h01;
      if ($realtime - t_wr < (oe_n ? 8.0 : 9.0)) viol = viol + 8'h01;
      in_wr = 1'b0;
    end
  end
endmodule : asbw_mem_model

`default_nettype wire

// File: test/tb.sv
/*
  Self-checking bench for the static memory host controller.
  Assumes the memory model stands on the pins and the clock is 40 MHz.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, reset, req_valid, req_write, standby_req;
  logic [asbw_pkg::ADDR_W-1:0] req_addr, word_select_lines;
  logic [asbw_pkg::DATA_W-1:0] req_wdata, rsp_rdata, byte_data_in;
  logic [asbw_pkg::DATA_W-1:0] byte_data_out, mem_q;
  logic [7:0] viol;
  logic req_ready, rsp_valid, standby_ack, chip_sel_n, out_drive_n;
  logic write_strobe_n, byte_data_oe, mem_drive;
  int num_errors, compares, cycles;

  asbw_host_ctrl uut (.clk_sys(clk_sys), .reset(reset),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .standby_req(standby_req),
    .standby_ack(standby_ack), .word_select_lines(word_select_lines),
    .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n),
    .write_strobe_n(write_strobe_n), .byte_data_in(byte_data_in),
    .byte_data_out(byte_data_out), .byte_data_oe(byte_data_oe));

  asbw_mem_model mem_i (.addr(word_select_lines), .cs_n(chip_sel_n),
    .oe_n(out_drive_n), .we_n(write_strobe_n), .dq(byte_data_in),
    .q(mem_q), .drive(mem_drive), .viol(viol));

  assign byte_data_in = byte_data_oe ? byte_data_out : mem_q;

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  // ==========================================================
  // checking and closing
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  always @(negedge clk_sys) begin
    if (!reset) check("bus_clash", byte_data_oe & mem_drive, 1'b0);
  end

  // ==========================================================
  // request driver: called at a falling edge, returns in cycle 0
  task automatic issue(input logic wr, input logic [14:0] a,
                       input logic [7:0] d);
    int n;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check("req_taken", req_ready, 1'b1);
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask : issue

  task automatic do_write(input logic [14:0] a, input logic [7:0] d);
    issue(1'b1, a, d);
    check("wr_setup", {chip_sel_n, byte_data_oe}, 2'b11);
    @(negedge clk_sys);
    check("wr_sel", chip_sel_n, 1'b0);
    check("wr_strobe", write_strobe_n, 1'b0);
    check("wr_drive", out_drive_n, 1'b1);
    check("wr_addr", word_select_lines, a);
    check("wr_data", byte_data_out, d);
    @(negedge clk_sys);
    check("wr_end", {chip_sel_n, write_strobe_n}, 2'b11);
    check("wr_hold", byte_data_oe, 1'b1);
    @(negedge clk_sys);
    check("wr_release", byte_data_oe, 1'b0);
    check("wr_ready", req_ready, 1'b1);
  endtask : do_write

  task automatic do_read(input logic [14:0] a, input logic [7:0] exp);
    int k;
    issue(1'b0, a, 8'h00);
    check("rd_setup", {chip_sel_n, word_select_lines}, {1'b1, a});
    k = 0;
    while (rsp_valid !== 1'b1 && k < 12) begin
      @(negedge clk_sys);
      k++;
      if (k == 1) check("rd_sel", {chip_sel_n, out_drive_n}, 2'b00);
      check("rd_strobe", write_strobe_n, 1'b1);
    end
    check("rd_latency", k, 7);
    check("rd_data", rsp_rdata, exp);
    check("rd_deselect", chip_sel_n, 1'b1);
    @(negedge clk_sys);
    check("rd_ready", req_ready, 1'b1);
  endtask : do_read

  // read request is refused through standby, then withdrawn; ready returns after one recovery cycle
  task automatic do_standby;
    standby_req = 1'b1;
    @(negedge clk_sys);
    @(negedge clk_sys);
    check("sb_ack", standby_ack, 1'b1);
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr = 15'h0123;
    repeat (3) begin
      @(negedge clk_sys);
      check("sb_refuse", {req_ready, chip_sel_n}, 2'b01);
    end
    req_valid = 1'b0;
    standby_req = 1'b0;
    @(negedge clk_sys);
    check("sb_exit", {standby_ack, req_ready, chip_sel_n}, 3'b001);
    @(negedge clk_sys);
    check("sb_recov", req_ready, 1'b1);
  endtask : do_standby

  // ==========================================================
  // main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    standby_req = 1'b0;
    repeat (16) @(negedge clk_sys);
    check("rst_pins", {chip_sel_n, out_drive_n, write_strobe_n,
          byte_data_oe}, 4'hE);
    reset = 1'b0;
    @(negedge clk_sys);
    @(negedge clk_sys);
    do_write(15'h0000, 8'hA5);
    do_write(15'h7FFF, 8'h5A);
    do_write(15'h2AAA, 8'h3C);
    do_read(15'h0000, 8'hA5);
    do_read(15'h7FFF, 8'h5A);
    do_read(15'h2AAA, 8'h3C);
    do_write(15'h2AAA, 8'hC3);
    do_read(15'h2AAA, 8'hC3);
    do_standby();
    do_read(15'h7FFF, 8'h5A);
    check("mem_timing", viol, 8'h00);
    wrap_up();
  end
endmodule : tb

`default_nettype wire
